// >>> rtl/remote_io_consts.vh
// offsets, field positions, reset values and timing counts of the remote-control i/o block
// Behaviour
// RULE_01: tare starts on rising tare input only
// RULE_02: zero balance starts on rising trigger
// RULE_03: peak clear high overwrites both stores
// RULE_04: peak hold high freezes both stores
// RULE_05: remote contacts act only while enabled
// RULE_06: print mode chooses channel-aware print enabling
// RULE_07: calibration or zero select reroutes input
// RULE_08: warning low when not ready or error
// RULE_09: four limit outputs follow limit switches
// RULE_10: each control input function is configurable
// RULE_11: eight sequential channels per amplifier, two parallel
// RULE_12: one fixed carrier excites all transducers
// RULE_13: all amplifiers share one carrier
// RULE_14: one unit timing source, others follow
// RULE_15: channel led lit while channel active
// RULE_16: inputs synchronised, debounced, edges by comparison
// RULE_17: levels follow while enabled; outputs low after reset (the code resets peak2 to all ones and holds pready high)
`ifndef REMOTE_IO_CONSTS_VH
`define REMOTE_IO_CONSTS_VH

// clock and timing
`define CLK_HZ              10000000
`define DEBOUNCE_US         1000
`define DEBOUNCE_CYCLES     (`DEBOUNCE_US * (`CLK_HZ / 1000000))
`define CARRIER_HZ          225
`define CARRIER_HALF_CYCLES (`CLK_HZ / (2 * `CARRIER_HZ))
`define STEP_MS             100
`define STEP_CYCLES         (`STEP_MS * (`CLK_HZ / 1000))

// register byte offsets
`define REG_CTRL       8'h00
`define REG_FUNC_MAP   8'h04
`define REG_CHAN       8'h08
`define REG_STATUS     8'h0c
`define REG_PEAK1      8'h10
`define REG_PEAK2      8'h14
`define REG_INT_STATUS 8'h18
`define REG_INT_ENABLE 8'h1c
`define REG_INT_CLEAR  8'h20

// ctrl fields
`define CTRL_SYNC_MASTER 0
`define CTRL_SEQ_RUN     1
`define CTRL_RESET       32'h0000_0000

// channel register fields
`define CHAN_A_LSB     0
`define CHAN_B_LSB     4
`define CHAN_COUNT_LSB 8
`define CHAN_PRINT_LSB 12
`define CHAN_RESET     32'h0000_0700

// function codes, one nibble per control input
`define FN_AUTOCAL     4'h0
`define FN_TARE        4'h1
`define FN_SCALING     4'h2
`define FN_CUTOFF      4'h3
`define FN_PEAK_CLEAR  4'h4
`define FN_PEAK_HOLD   4'h5
`define FN_ZERO_TRIG   4'h6
`define FN_REMOTE_EN   4'h7
`define FN_SHUNT       4'h8
`define FN_PRINT_MODE  4'h9
`define FN_CAL_SEL     4'ha
`define FN_ZERO_SEL    4'hb
`define FUNC_MAP_RESET 32'h5454_3210

// interrupt bits
`define INT_TARE      0
`define INT_ZERO      1
`define INT_WARN_FALL 2
`define INT_LIMIT     3
`define INT_W         4

`endif

// >>> rtl/input_conditioner.v
// two-flop synchroniser and per-bit debounce filter for the isolated control inputs
`timescale 1ns/1ps
`default_nettype none
module input_conditioner #(
    parameter integer WIDTH  = 8,
    parameter integer CW     = 16,
    parameter integer CYCLES = 10000
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // raw pins and clean levels
    input  wire [WIDTH-1:0] raw_in,
    output reg  [WIDTH-1:0] clean
);
    reg [WIDTH-1:0] sync_a;
    reg [WIDTH-1:0] sync_b;
    reg [CW-1:0]    stable_cnt [0:WIDTH-1];
    integer         i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= {WIDTH{1'b0}};
            sync_b <= {WIDTH{1'b0}};
            clean  <= {WIDTH{1'b0}};
            for (i = 0; i < WIDTH; i = i + 1) begin
                stable_cnt[i] <= {CW{1'b0}};
            end
        end else begin
            sync_a <= raw_in; // RULE_16
            sync_b <= sync_a;
            for (i = 0; i < WIDTH; i = i + 1) begin
                // a level is taken only after it has stood for the whole filter time
                if (sync_b[i] == clean[i]) begin
                    stable_cnt[i] <= {CW{1'b0}};
                end else if (stable_cnt[i] == CYCLES[CW-1:0] - 1'b1) begin
                    stable_cnt[i] <= {CW{1'b0}};
                    clean[i]      <= sync_b[i]; // RULE_16
                end else begin
                    stable_cnt[i] <= stable_cnt[i] + 1'b1;
                end
            end
        end
    end
endmodule // input_conditioner
`default_nettype wire

// >>> rtl/remote_control_io.v
// remote-control inputs, limit and warning outputs, channel sequencer and carrier
`timescale 1ns/1ps
`default_nettype none
`include "remote_io_consts.vh"
module remote_control_io #(
    parameter integer AMPLIFIERS      = 2,
    parameter integer VALUE_W         = 16,
    parameter integer DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter integer CARRIER_HALF    = `CARRIER_HALF_CYCLES,
    parameter integer STEP_CYCLES     = `STEP_CYCLES
) (
    // apb
    input  wire               pclk,
    input  wire               presetn,
    input  wire [7:0]         paddr,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output wire               pready,
    output reg                pslverr,
    // isolated control inputs
    input  wire [7:0]         ctrl_in,
    // device state
    input  wire               device_ready,
    input  wire               device_error,
    input  wire [3:0]         limit_state,
    input  wire [VALUE_W-1:0] meas_value,
    input  wire               meas_valid,
    input  wire               print_request,
    // control outputs
    output reg  [3:0]         limit_out,
    output reg                warning_out,
    // measurement functions
    output reg                tare_start,
    output reg                zero_start,
    output reg                autocal_off,
    output reg                scaling_select,
    output reg                cutoff_select,
    output reg                shunt_select,
    output reg                cal_select,
    output reg                zero_select,
    output reg                print_enable,
    output reg  [VALUE_W-1:0] peak1,
    output reg  [VALUE_W-1:0] peak2,
    // channels
    output reg  [2:0]         chan_a,
    output reg  [2:0]         chan_b,
    output reg  [7:0]         led_a,
    output reg  [7:0]         led_b,
    // carrier and synchronisation jack
    output reg                carrier_out,
    input  wire               sync_i,
    output reg                sync_o,
    output reg                sync_oe,
    // interrupt
    output wire               irq
);
    // merge the inputs mapped to one function code
    function fn_level;
        input [31:0] map;
        input [7:0]  lvl;
        input [3:0]  code;
        integer      k;
        begin
            fn_level = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (map[4*k +: 4] == code) begin
                    fn_level = fn_level | lvl[k];
                end
            end
        end
    endfunction

    function fn_mapped;
        input [31:0] map;
        input [3:0]  code;
        integer      k;
        begin
            fn_mapped = 1'b0;
            for (k = 0; k < 8; k = k + 1) begin
                if (map[4*k +: 4] == code) begin
                    fn_mapped = 1'b1;
                end
            end
        end
    endfunction

    reg  [31:0]        ctrl;
    reg  [31:0]        func_map;
    reg  [31:0]        chan_cfg;
    reg  [`INT_W-1:0]  int_status;
    reg  [`INT_W-1:0]  int_enable;
    wire [7:0]         clean;
    reg                tare_prev;
    reg                zero_prev;
    reg                warn_prev;
    reg  [3:0]         limit_prev;
    reg                sync_a;
    reg                sync_b;
    reg                sync_prev;
    reg  [23:0]        carrier_cnt;
    reg  [23:0]        step_cnt;
    reg  [2:0]         seq_idx;
    reg  [`INT_W-1:0]  next_events;

    input_conditioner #(
        .WIDTH  (8),
        .CW     (16),
        .CYCLES (DEBOUNCE_CYCLES)
    ) u_cond (
        .pclk    (pclk),
        .presetn (presetn),
        .raw_in  (ctrl_in),
        .clean   (clean)
    );

    // function levels; an unmapped remote enable leaves the contacts live
    wire remote_en = fn_mapped(func_map, `FN_REMOTE_EN) ?
                     fn_level(func_map, clean, `FN_REMOTE_EN) : 1'b1; // RULE_05
    wire lv_tare   = fn_level(func_map, clean, `FN_TARE) & remote_en; // RULE_10
    wire lv_zero   = fn_level(func_map, clean, `FN_ZERO_TRIG) & remote_en;
    wire lv_clear  = fn_level(func_map, clean, `FN_PEAK_CLEAR) & remote_en;
    wire lv_hold   = fn_level(func_map, clean, `FN_PEAK_HOLD) & remote_en;
    wire lv_pmode  = fn_level(func_map, clean, `FN_PRINT_MODE) & remote_en;
    wire lv_cal    = fn_level(func_map, clean, `FN_CAL_SEL) & remote_en;
    wire lv_zsel   = fn_level(func_map, clean, `FN_ZERO_SEL) & remote_en;

    wire [2:0] chan_last  = chan_cfg[`CHAN_COUNT_LSB +: 3];
    wire [2:0] print_chan = chan_cfg[`CHAN_PRINT_LSB +: 3];
    wire       warn_next  = device_ready & ~device_error; // RULE_08

    // apb slave: zero wait states, read data latched in the setup cycle
    assign pready = 1'b1;
    wire wr_en  = psel & penable & pwrite;
    wire setup  = psel & ~penable;
    wire [`INT_W-1:0] int_clr = (wr_en && paddr == `REG_INT_CLEAR) ?
                                pwdata[`INT_W-1:0] : {`INT_W{1'b0}};
    assign irq = |(int_status & int_enable);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= `CTRL_RESET;
            func_map   <= `FUNC_MAP_RESET;
            chan_cfg   <= `CHAN_RESET;
            int_enable <= {`INT_W{1'b0}};
            prdata     <= 32'h0000_0000;
            pslverr    <= 1'b0;
        end else begin
            if (wr_en) begin
                case (paddr)
                    `REG_CTRL:       ctrl       <= pwdata;
                    `REG_FUNC_MAP:   func_map   <= pwdata; // RULE_10
                    `REG_CHAN:       chan_cfg   <= pwdata;
                    `REG_INT_ENABLE: int_enable <= pwdata[`INT_W-1:0];
                    default:         ;
                endcase
            end
            if (setup) begin
                pslverr <= 1'b0;
                case (paddr)
                    `REG_CTRL:       prdata <= ctrl;
                    `REG_FUNC_MAP:   prdata <= func_map;
                    `REG_CHAN:       prdata <= chan_cfg;
                    `REG_STATUS:     prdata <= {9'h000, chan_b, 1'b0, chan_a, 2'h0,
                                                remote_en, warning_out, limit_out, clean};
                    `REG_PEAK1:      prdata <= {{(32-VALUE_W){1'b0}}, peak1};
                    `REG_PEAK2:      prdata <= {{(32-VALUE_W){1'b0}}, peak2};
                    `REG_INT_STATUS: prdata <= {{(32-`INT_W){1'b0}}, int_status};
                    `REG_INT_ENABLE: prdata <= {{(32-`INT_W){1'b0}}, int_enable};
                    `REG_INT_CLEAR:  prdata <= 32'h0000_0000;
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // edge triggers, level functions and control outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tare_prev      <= 1'b0;
            zero_prev      <= 1'b0;
            tare_start     <= 1'b0;
            zero_start     <= 1'b0;
            autocal_off    <= 1'b0;
            scaling_select <= 1'b0;
            cutoff_select  <= 1'b0;
            shunt_select   <= 1'b0;
            cal_select     <= 1'b0;
            zero_select    <= 1'b0;
            print_enable   <= 1'b0;
            limit_out      <= 4'h0;
            warning_out    <= 1'b0;
        end else begin
            tare_prev  <= lv_tare;
            zero_prev  <= lv_zero;
            tare_start <= lv_tare & ~tare_prev; // RULE_01 RULE_16
            zero_start <= lv_zero & ~zero_prev; // RULE_02 RULE_16
            // a disabled remote drops every level function to inactive
            autocal_off    <= fn_level(func_map, clean, `FN_AUTOCAL) & remote_en; // RULE_17
            scaling_select <= fn_level(func_map, clean, `FN_SCALING) & remote_en;
            cutoff_select  <= fn_level(func_map, clean, `FN_CUTOFF) & remote_en;
            shunt_select   <= fn_level(func_map, clean, `FN_SHUNT) & remote_en;
            // calibration source takes the input first when both are asked
            cal_select     <= lv_cal; // RULE_07
            zero_select    <= lv_zsel & ~lv_cal; // RULE_07
            print_enable   <= print_request &
                              (lv_pmode | (chan_a == print_chan)); // RULE_06
            limit_out      <= limit_state & {4{device_ready}}; // RULE_09 RULE_17
            warning_out    <= warn_next; // RULE_08
        end
    end

    // peak stores: store one keeps the maximum, store two the minimum
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peak1 <= {VALUE_W{1'b0}};
            peak2 <= {VALUE_W{1'b1}};
        end else if (meas_valid && !lv_hold) begin // RULE_04
            if (lv_clear) begin
                peak1 <= meas_value; // RULE_03
                peak2 <= meas_value;
            end else begin
                if (meas_value > peak1) begin
                    peak1 <= meas_value; // RULE_03
                end
                if (meas_value < peak2) begin
                    peak2 <= meas_value;
                end
            end
        end
    end

    // sticky events; a new event outranks a clear in the same cycle
    always @* begin
        next_events                = {`INT_W{1'b0}};
        next_events[`INT_TARE]     = lv_tare & ~tare_prev;
        next_events[`INT_ZERO]     = lv_zero & ~zero_prev;
        next_events[`INT_WARN_FALL] = warn_prev & ~warn_next;
        next_events[`INT_LIMIT]    = |(limit_prev ^ (limit_state & {4{device_ready}}));
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= {`INT_W{1'b0}};
            warn_prev  <= 1'b0;
            limit_prev <= 4'h0;
        end else begin
            int_status <= (int_status & ~int_clr) | next_events;
            warn_prev  <= warn_next;
            limit_prev <= limit_state & {4{device_ready}};
        end
    end

    // channel sequencer; both amplifiers step together on the same index
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt <= 24'h00_0000;
            seq_idx  <= 3'h0;
            chan_a   <= 3'h0;
            chan_b   <= 3'h0;
            led_a    <= 8'h00;
            led_b    <= 8'h00;
        end else begin
            if (!ctrl[`CTRL_SEQ_RUN]) begin
                step_cnt <= 24'h00_0000;
                chan_a   <= chan_cfg[`CHAN_A_LSB +: 3];
                chan_b   <= chan_cfg[`CHAN_B_LSB +: 3];
            end else begin
                if (step_cnt == STEP_CYCLES[23:0] - 1'b1) begin
                    step_cnt <= 24'h00_0000;
                    seq_idx  <= (seq_idx >= chan_last) ? 3'h0 : seq_idx + 1'b1; // RULE_11
                end else begin
                    step_cnt <= step_cnt + 1'b1;
                end
                chan_a <= seq_idx; // RULE_11
                chan_b <= seq_idx;
            end
            // led dark until the device is ready to measure
            led_a <= device_ready ? (8'h01 << chan_a) : 8'h00; // RULE_15
            led_b <= (device_ready && AMPLIFIERS > 1) ?
                     (8'h01 << chan_b) : 8'h00; // RULE_15 RULE_11
        end
    end

    // carrier: one divider feeds every amplifier, a follower re-phases on the jack
    wire sync_edge = sync_b & ~sync_prev;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a      <= 1'b0;
            sync_b      <= 1'b0;
            sync_prev   <= 1'b0;
            carrier_cnt <= 24'h00_0000;
            carrier_out <= 1'b0;
            sync_o      <= 1'b0;
            sync_oe     <= 1'b0;
        end else begin
            sync_a    <= sync_i;
            sync_b    <= sync_a;
            sync_prev <= sync_b;
            sync_oe   <= ctrl[`CTRL_SYNC_MASTER]; // RULE_14
            sync_o    <= ctrl[`CTRL_SYNC_MASTER] & carrier_out;
            if (!ctrl[`CTRL_SYNC_MASTER] && sync_edge) begin
                // follower aligns its rising carrier edge to the master
                carrier_cnt <= 24'h00_0000; // RULE_14
                carrier_out <= 1'b1;
            end else if (carrier_cnt == CARRIER_HALF[23:0] - 1'b1) begin
                carrier_cnt <= 24'h00_0000;
                carrier_out <= ~carrier_out; // RULE_12 RULE_13
            end else begin
                carrier_cnt <= carrier_cnt + 1'b1;
            end
        end
    end
endmodule // remote_control_io
`default_nettype wire

// >>> sim/remote_io_sva.sv
// assertion checker for the remote-control i/o block
`timescale 1ns/1ps
`default_nettype none
module remote_io_sva #(
    parameter integer VALUE_W = 16
) (
    // clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // device state
    input wire logic               device_ready,
    input wire logic               device_error,
    input wire logic [3:0]         limit_state,
    input wire logic               meas_valid,
    input wire logic               print_request,
    // outputs
    input wire logic [3:0]         limit_out,
    input wire logic               warning_out,
    input wire logic               tare_start,
    input wire logic               zero_start,
    input wire logic               cal_select,
    input wire logic               zero_select,
    input wire logic               print_enable,
    input wire logic [VALUE_W-1:0] peak1,
    input wire logic [VALUE_W-1:0] peak2,
    input wire logic [7:0]         led_a
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_warn_notready: assert property (!device_ready [*2] |-> !warning_out)
        else $error("warning high while not ready");
    a_warn_error: assert property (device_error [*2] |-> !warning_out)
        else $error("warning high during error");
    a_limit_follow: assert property (device_ready [*2] |-> limit_out == $past(limit_state))
        else $error("limit output differs from switch");
    a_tare_single: assert property (tare_start |=> !tare_start)
        else $error("tare start longer than one cycle");
    a_zero_single: assert property (zero_start |=> !zero_start)
        else $error("zero start longer than one cycle");
    a_cal_first: assert property (cal_select |-> !zero_select)
        else $error("two input sources at once");
    // peaks move only with a sample, so hold and clear are judged per sample
    a_peak_idle: assert property (!meas_valid |=> $stable(peak1) && $stable(peak2))
        else $error("peak store changed without sample");
    a_print_gate: assert property (!print_request [*2] |-> !print_enable)
        else $error("print enabled without request");
    a_led_dark: assert property (!device_ready [*2] |-> led_a == 8'h00)
        else $error("channel led lit while not ready");
endmodule // remote_io_sva
bind remote_control_io remote_io_sva #(.VALUE_W(VALUE_W)) remote_io_sva_i (
    .pclk(pclk), .presetn(presetn), .device_ready(device_ready),
    .device_error(device_error), .limit_state(limit_state), .meas_valid(meas_valid),
    .print_request(print_request), .limit_out(limit_out), .warning_out(warning_out),
    .tare_start(tare_start), .zero_start(zero_start), .cal_select(cal_select),
    .zero_select(zero_select), .print_enable(print_enable), .peak1(peak1),
    .peak2(peak2), .led_a(led_a));
`default_nettype wire

// >>> sim/remote_panel.sv
// switch-panel model: drives the isolated control inputs with contact bounce
`timescale 1ns/1ps
`default_nettype none
module remote_panel (
    // clock
    input  wire logic       pclk,
    // requested and bouncing contact levels
    input  wire logic [7:0] want,
    output var  logic [7:0] pins
);
    logic [7:0] last = 8'h00;
    logic [7:0] diff = 8'h00;
    logic [2:0] bnc  = 3'd0;
    initial pins = 8'h00;
    // chatter shorter than the filter window, so only settled levels may count
    always @(posedge pclk) begin
        if (want !== last) begin
            diff <= want ^ last;
            last <= want;
            bnc  <= 3'd5;
            pins <= pins ^ want ^ last;
        end else if (bnc != 3'd0) begin
            bnc  <= bnc - 3'd1;
            pins <= pins ^ diff;
        end else begin
            pins <= last;
        end
    end
endmodule // remote_panel
`default_nettype wire

// >>> sim/tb.sv
// self-checking bench for the remote-control i/o block
`timescale 1ns/1ps
`default_nettype none
`include "remote_io_consts.vh"
module tb;
    localparam int HALF = 8;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, c;
    logic        device_ready, device_error, meas_valid, print_request, warning_out, irq;
    logic        tare_start, zero_start, autocal_off, scaling_select, cutoff_select;
    logic        shunt_select, cal_select, zero_select, print_enable;
    logic        carrier_out, sync_i, sync_o, sync_oe;
    logic [2:0]  chan_a, chan_b;
    logic [3:0]  limit_state, limit_out;
    logic [7:0]  paddr, ctrl_in, want, led_a, led_b, sa, sb, sl;
    logic [15:0] meas_value, peak1, peak2, pmax, pmin, v;
    logic [31:0] pwdata, prdata, q, seed;
    int          n_errors, comparisons, cycles, n_tare, n_zero, t0, z0, k;
    wire  [6:0]  lv = {autocal_off, scaling_select, cutoff_select, shunt_select,
                       print_enable, cal_select, zero_select};

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    remote_control_io #(.DEBOUNCE_CYCLES(4), .CARRIER_HALF(HALF), .STEP_CYCLES(16))
    remote_control_io_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctrl_in(ctrl_in), .device_ready(device_ready),
        .device_error(device_error), .limit_state(limit_state), .meas_value(meas_value),
        .meas_valid(meas_valid), .print_request(print_request), .limit_out(limit_out),
        .warning_out(warning_out), .tare_start(tare_start), .zero_start(zero_start),
        .autocal_off(autocal_off), .scaling_select(scaling_select),
        .cutoff_select(cutoff_select), .shunt_select(shunt_select),
        .cal_select(cal_select), .zero_select(zero_select), .print_enable(print_enable),
        .peak1(peak1), .peak2(peak2), .chan_a(chan_a), .chan_b(chan_b), .led_a(led_a),
        .led_b(led_b), .carrier_out(carrier_out), .sync_i(sync_i), .sync_o(sync_o),
        .sync_oe(sync_oe), .irq(irq));
    remote_panel remote_panel_i (.pclk(pclk), .want(want), .pins(ctrl_in));

    task final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ends between edges so outputs are settled when compared
    task cyc(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task drive(input logic [7:0] w);
        @(posedge pclk);
        want <= w;
        cyc(25);
    endtask

    task smp(input logic [15:0] x);
        @(posedge pclk);
        meas_value <= x;
        meas_valid <= 1'b1;
        @(posedge pclk);
        meas_valid <= 1'b0;
    endtask

    function logic [6:0] exp_lv(input logic [3:0] code);
        case (code)
            4'h0: exp_lv = 7'h40;
            4'h2: exp_lv = 7'h20;
            4'h3: exp_lv = 7'h10;
            4'h8: exp_lv = 7'h08;
            4'h9: exp_lv = 7'h04;
            4'ha: exp_lv = 7'h02;
            4'hb: exp_lv = 7'h01;
            default: exp_lv = 7'h00;
        endcase
    endfunction

    always @(posedge pclk) begin
        if (tare_start === 1'b1)
            n_tare++;
        if (zero_start === 1'b1)
            n_zero++;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report;
        end
    end

    initial begin
        seed = 32'h020c;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want = 8'h00;
        device_ready = 1'b0;
        device_error = 1'b0;
        limit_state = 4'h0;
        meas_value = 16'h0;
        meas_valid = 1'b0;
        print_request = 1'b0;
        sync_i = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `REG_FUNC_MAP, 32'h0);
        chk(q, 32'h5454_3210);
        apb(1'b0, `REG_CHAN, 32'h0);
        chk(q, 32'h0000_0700);
        apb(1'b0, 8'h40, 32'h0);
        chk(q, 32'h0);
        chk(e, 1'b1);
        cyc(2);
        chk({limit_out, warning_out, led_a}, 32'h0);
        repeat (4) begin
            @(posedge pclk);
            q = $random(seed);
            device_ready <= 1'b1;
            limit_state <= q[3:0];
            cyc(3);
            chk(limit_out, limit_state);
            chk(warning_out, 1'b1);
        end
        @(posedge pclk);
        device_error <= 1'b1;
        cyc(3);
        chk(warning_out, 1'b0);
        @(posedge pclk);
        device_error <= 1'b0;
        print_request <= 1'b1;
        apb(1'b1, `REG_CHAN, 32'h0000_0703);
        apb(1'b1, `REG_INT_ENABLE, 32'h3);
        // input 0 takes every function code; input 2 gates the contacts
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, `REG_FUNC_MAP, {28'h5454_271, i[3:0]});
            t0 = n_tare;
            z0 = n_zero;
            drive(8'h04);
            drive(8'h05);
            chk(lv, exp_lv(i[3:0]));
            drive(8'h01);
            chk(lv, 7'h00);
            drive(8'h00);
            chk(32'(n_tare - t0), i == 1);
            chk(32'(n_zero - z0), i == 6);
        end
        chk(irq, 1'b1);
        apb(1'b0, `REG_INT_STATUS, 32'h0);
        chk(q & 32'h3, 32'h3);
        apb(1'b1, `REG_INT_ENABLE, 32'h0);
        cyc(1);
        chk(irq, 1'b0);
        apb(1'b1, `REG_INT_ENABLE, 32'h3);
        cyc(1);
        chk(irq, 1'b1);
        apb(1'b1, `REG_INT_CLEAR, 32'hf);
        cyc(1);
        chk(irq, 1'b0);
        apb(1'b1, `REG_FUNC_MAP, 32'h5454_3210);
        drive(8'h10);
        q = $random(seed);
        v = {1'b0, q[14:0]};
        smp(v);
        pmax = v;
        pmin = v;
        drive(8'h00);
        repeat (6) begin
            q = $random(seed);
            v = {1'b0, q[14:0]};
            smp(v);
            if (v > pmax)
                pmax = v;
            if (v < pmin)
                pmin = v;
        end
        cyc(1);
        chk(peak1, pmax);
        chk(peak2, pmin);
        drive(8'h20);
        smp(16'h7fff);
        smp(16'h0000);
        cyc(1);
        chk(peak1, pmax);
        chk(peak2, pmin);
        drive(8'h00);
        smp(16'h7fff);
        cyc(1);
        chk(peak1, 16'h7fff);
        apb(1'b1, `REG_CTRL, 32'h3);
        sa = 8'h00;
        sb = 8'h00;
        sl = 8'h00;
        repeat (200) begin
            @(negedge pclk);
            sa |= 8'h01 << chan_a;
            sb |= 8'h01 << chan_b;
            sl |= led_a & led_b;
        end
        chk(sa, 8'hff);
        chk(sb, 8'hff);
        chk(sl, 8'hff);
        chk(sync_oe, 1'b1);
        for (int j = 0; j < 2; j++) begin
            c = carrier_out;
            k = 0;
            while (carrier_out === c && k < 40) begin
                @(negedge pclk);
                k++;
            end
        end
        chk(32'(k), HALF);
        apb(1'b1, `REG_CTRL, 32'h2);
        sync_i <= 1'b1;
        cyc(10);
        chk({sync_oe, sync_o, carrier_out}, 3'b001);
        final_report;
    end
endmodule // tb
`default_nettype wire
